// File: core_launch_consts.svh
`ifndef CORE_LAUNCH_CONSTS_SVH
`define CORE_LAUNCH_CONSTS_SVH
`define NUM_CORES        8
`define CORE_IDX_W       3
`define LOAD_LONGS       16'h01F0
`define LOAD_LAST        9'h1EF
`define LOCAL_ADDR_W     9
`define HUB_ADDR_W       16
`define PARAM_LO         2
`define PARAM_HI         15
`define RESULT_FAIL      4'hF
`define START_ADDR       9'h000
`define LONG_BYTES       16'h0004
`endif

// File: core_launch_pkg.sv
package core_launch_pkg;
   typedef enum logic [1:0] {
      op_none,
      op_launch_next,
      op_launch_at,
      op_stop
   } op_e;

   typedef struct packed {
      op_e         op;
      logic [2:0]  core_index;
      logic [15:0] routine_addr;
      logic [15:0] param;
   } launch_req_s;

   typedef struct packed {
      logic        valid;
      logic [2:0]  core;
      logic [8:0]  addr;
      logic [31:0] data;
   } local_wr_s;
endpackage

// File: core_pick.sv
`timescale 1ns/1ps
`include "core_launch_consts.svh"
module core_pick
   import core_launch_pkg::*;
(
   // free map in, choice out
   input  wire logic [7:0] free_map,
   output logic             found,
   output logic [2:0]       index
);
   always_comb begin
      found = 1'b0;
      index = 3'h0;
      for (int i = `NUM_CORES - 1; i >= 0; i--) begin
         if (free_map[i]) begin
            found = 1'b1;
            index = 3'(i);
         end
      end
   end
endmodule

// File: core_launch_stop_control.sv
// Operation
// - launch-next finds a free core and assigns the launch to it
// - launch copies 496 longs from hub starting at routine address
// - boot parameter keeps bits 2..15, low two bits forced zero
// - in the same cycle as the parameter load all other special registers are cleared
// - launched core starts executing at local address 0
// - stop by index 0..7 makes exactly that core dormant
// - dormant core gets no clock pulses until relaunched
// - launch-next returns core index, or -1 when none free
// - launch-at stops and restarts indexed core, even the requester
`timescale 1ns/1ps
`include "core_launch_consts.svh"
module core_launch_stop_control
   import core_launch_pkg::*;
(
   // clock and reset
   input  wire logic         clock,
   input  wire logic         rst_n,
   // request from a core
   input  wire launch_req_s  req,
   input  wire logic         req_valid,
   output logic             req_ready,
   output logic             done,
   output logic [3:0]       result,
   // hub read port
   output logic             hub_rd,
   output logic [15:0]      hub_addr,
   input  wire logic         hub_ack,
   input  wire logic [31:0] hub_data,
   // target core side
   output local_wr_s        local_wr,
   output logic [7:0]       clock_gate_en,
   output logic [7:0]       core_run,
   output logic [7:0]       clear_special,
   output logic [15:0]      boot_parameter_register,
   output logic [7:0]       boot_param_load,
   output logic [8:0]       start_pc
);
   typedef enum logic [1:0] {idle, copy, init} state_e;
   state_e      state;
   logic [2:0]  target;
   logic [15:0] param_hold;
   logic [8:0]  word_cnt;
   logic        pick_found;
   logic [2:0]  pick_index;

   // one-hot select of a core
   function automatic logic [7:0] onehot(input logic [2:0] i);
      onehot = 8'h01 << i;
   endfunction

   core_pick u_pick (
      .free_map (~core_run),
      .found    (pick_found),
      .index    (pick_index)
   );

   // taken only while idle; requests during a load wait
   wire take = req_valid && req_ready;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state      <= idle;
         target     <= 3'h0;
         param_hold <= 16'h0000;
         word_cnt   <= 9'h000;
         req_ready  <= 1'b1;
         done       <= 1'b0;
         result     <= 4'h0;
         hub_rd     <= 1'b0;
         hub_addr   <= 16'h0000;
         local_wr   <= '0;
         core_run   <= 8'h00;
         clear_special <= 8'h00;
         boot_parameter_register <= 16'h0000;
         boot_param_load <= 8'h00;
         start_pc   <= 9'h000;
      end else begin
         done            <= 1'b0;
         local_wr.valid  <= 1'b0;
         clear_special   <= 8'h00;
         boot_param_load <= 8'h00;
         case (state)
            idle: begin
               if (take) begin
                  case (req.op)
                     op_stop: begin
                        core_run <= core_run & ~onehot(req.core_index);
                        done     <= 1'b1;
                        result   <= {1'b0, req.core_index};
                     end
                     op_launch_next: begin
                        if (!pick_found) begin
                           done   <= 1'b1;
                           result <= `RESULT_FAIL;
                        end else begin
                           core_run   <= core_run | onehot(pick_index);
                           target     <= pick_index;
                           param_hold <= req.param;
                           hub_addr   <= req.routine_addr;
                           hub_rd     <= 1'b1;
                           word_cnt   <= 9'h000;
                           req_ready  <= 1'b0;
                           state      <= copy;
                        end
                     end
                     op_launch_at: begin
                        core_run   <= core_run | onehot(req.core_index);
                        clear_special <= onehot(req.core_index);
                        target     <= req.core_index;
                        param_hold <= req.param;
                        hub_addr   <= req.routine_addr;
                        hub_rd     <= 1'b1;
                        word_cnt   <= 9'h000;
                        req_ready  <= 1'b0;
                        state      <= copy;
                     end
                     default: ;
                  endcase
               end
            end
            copy: begin
               if (hub_ack) begin
                  local_wr.valid <= 1'b1;
                  local_wr.core  <= target;
                  local_wr.addr  <= word_cnt;
                  local_wr.data  <= hub_data;
                  hub_addr       <= hub_addr + `LONG_BYTES;
                  word_cnt       <= word_cnt + 9'h001;
                  if (word_cnt == `LOAD_LAST) begin
                     hub_rd <= 1'b0;
                     state  <= init;
                  end
               end
            end
            init: begin
               boot_parameter_register <= {param_hold[`PARAM_HI:`PARAM_LO], 2'b00};
               boot_param_load <= onehot(target);
               clear_special <= onehot(target);
               start_pc  <= `START_ADDR;
               done      <= 1'b1;
               result    <= {1'b0, target};
               req_ready <= 1'b1;
               state     <= idle;
            end
            default: state <= idle;
         endcase
      end
   end

   // clock gated while dormant or loading
   // stop and restart cut the clock at the taking edge, one cycle sooner than core_run would
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         clock_gate_en <= 8'h00;
      end else if (take && (req.op == op_stop || req.op == op_launch_at)) begin
         clock_gate_en <= core_run & ~onehot(req.core_index);
      end else if (state == copy) begin
         clock_gate_en <= core_run & ~onehot(target);
      end else begin
         clock_gate_en <= core_run;
      end
   end

   a_param_aligned: assert property (@(posedge clock) disable iff (!rst_n)
      boot_parameter_register[1:0] == 2'b00) else $error("boot parameter not long aligned");

   a_param_loaded: assert property (@(posedge clock) disable iff (!rst_n)
      (|boot_param_load) |-> boot_parameter_register[`PARAM_HI:`PARAM_LO] == param_hold[`PARAM_HI:`PARAM_LO])
      else $error("boot parameter lost upper bits");

   a_dormant_gated: assert property (@(posedge clock) disable iff (!rst_n)
      (clock_gate_en & ~core_run) == 8'h00) else $error("dormant core clocked");

   a_reload_gated: assert property (@(posedge clock) disable iff (!rst_n)
      (state == copy) |-> !clock_gate_en[target]) else $error("core clocked while reloading");

   a_stop_clears: assert property (@(posedge clock) disable iff (!rst_n)
      (take && req.op == op_stop && state == idle) |=> !core_run[$past(req.core_index)])
      else $error("stopped core still running");

   a_stop_answer: assert property (@(posedge clock) disable iff (!rst_n)
      (take && req.op == op_stop) |=> (done && result == {1'b0, $past(req.core_index)}))
      else $error("stop not answered with its index");

   a_launch_claims: assert property (@(posedge clock) disable iff (!rst_n)
      (take && req.op == op_launch_next && core_run != 8'hFF) |=> (state == copy && core_run[target]))
      else $error("launch did not claim a core");

   a_lowest_free: assert property (@(posedge clock) disable iff (!rst_n)
      (take && req.op == op_launch_next && core_run != 8'hFF)
      |=> ((~$past(core_run) & onehot(target)) != 8'h00 && (~$past(core_run) & (onehot(target) - 8'h01)) == 8'h00))
      else $error("launch skipped a lower free core");

   a_full_fails: assert property (@(posedge clock) disable iff (!rst_n)
      (take && req.op == op_launch_next && core_run == 8'hFF) |=> (done && result == `RESULT_FAIL))
      else $error("no fail code when all busy");

   a_copy_bound: assert property (@(posedge clock) disable iff (!rst_n)
      (state == copy) |-> word_cnt <= `LOAD_LAST) else $error("copy overran 496 longs");

   a_copy_ends: assert property (@(posedge clock) disable iff (!rst_n)
      (state == copy && hub_ack && word_cnt == `LOAD_LAST) |=> (state == init && !hub_rd))
      else $error("copy did not stop after the last long");

   a_start_zero: assert property (@(posedge clock) disable iff (!rst_n)
      (|boot_param_load) |-> (start_pc == `START_ADDR && clear_special == boot_param_load))
      else $error("start not at local zero");
endmodule

// File: hub_model.sv
`timescale 1ns/1ps
module hub_model (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // hub read port
   input  wire logic        hub_rd,
   input  wire logic [15:0] hub_addr,
   input  wire logic [1:0]  slow,
   output logic             hub_ack,
   output logic [31:0]      hub_data
);
   logic [1:0] wait_cnt;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hub_ack  <= 1'b0;
         wait_cnt <= 2'h0;
         hub_data <= 32'h0000_0000;
      end else if (hub_rd && !hub_ack && wait_cnt == 2'h0) begin
         hub_ack  <= 1'b1;
         wait_cnt <= slow;
         hub_data <= {hub_addr, ~hub_addr};
      end else begin
         // inverted each cycle outside an ack, so the stale word returns every second cycle
         hub_ack  <= 1'b0;
         hub_data <= ~hub_data;
         if (wait_cnt != 2'h0) wait_cnt <= wait_cnt - 2'h1;
      end
   end
endmodule

// File: core_launch_stop_control_tb.sv
`timescale 1ns/1ps
module core_launch_stop_control_tb;
   import core_launch_pkg::*;
   logic        clock, rst_n, req_valid, req_ready, done, hub_rd, hub_ack;
   logic [1:0]  slow;
   logic [3:0]  result;
   logic [15:0] hub_addr, boot_parameter_register, exp_base, exp_word;
   logic [31:0] hub_data;
   logic [7:0]  clock_gate_en, core_run, clear_special, boot_param_load;
   logic [8:0]  start_pc;
   logic [2:0]  exp_core;
   launch_req_s req;
   local_wr_s   local_wr;
   int          failures, comparisons, nwr;
   core_launch_stop_control dut (.clock(clock), .rst_n(rst_n), .req(req), .req_valid(req_valid),
      .req_ready(req_ready), .done(done), .result(result), .hub_rd(hub_rd), .hub_addr(hub_addr),
      .hub_ack(hub_ack), .hub_data(hub_data), .local_wr(local_wr), .clock_gate_en(clock_gate_en),
      .core_run(core_run), .clear_special(clear_special), .boot_parameter_register(boot_parameter_register),
      .boot_param_load(boot_param_load), .start_pc(start_pc));
   hub_model hub (.clock(clock), .rst_n(rst_n), .hub_rd(hub_rd), .hub_addr(hub_addr), .slow(slow),
      .hub_ack(hub_ack), .hub_data(hub_data));
   task automatic check(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1) begin
         failures++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask
   always @(posedge clock) begin
      if (local_wr.valid === 1'b1) begin
         exp_word = exp_base + {5'h0, nwr[8:0], 2'h0};
         check(local_wr.addr === nwr[8:0] && local_wr.core === exp_core, "word place");
         check(local_wr.data === {exp_word, ~exp_word}, "word data");
         check(clock_gate_en[exp_core] === 1'b0 && req_ready === 1'b0, "loading core clocked");
         nwr = nwr + 1;
      end
   end
   task automatic issue(input op_e op, input logic [2:0] idx, input logic [15:0] a, input logic [15:0] p);
      int n;
      exp_base = a;
      nwr = 0;
      @(posedge clock);
      req <= '{op, idx, a, p};
      req_valid <= 1'b1;
      @(posedge clock);
      req_valid <= 1'b0;
      n = 0;
      // a stop answers one cycle after the take, so look before waiting
      #1;
      while (done !== 1'b1 && n < 3000) begin
         @(posedge clock);
         #1;
         n++;
      end
      check(done === 1'b1, "no done");
   endtask
   // caller passes a long-aligned routine address; ep is the parameter the core should see
   task automatic launch(input op_e op, input logic [2:0] idx, input logic [3:0] res, input logic [15:0] a,
                         input logic [15:0] p, input logic [15:0] ep);
      exp_core = res[2:0];
      issue(op, idx, a, p);
      if (op == op_launch_next) check(result === res, "result");
      check(nwr === 496 && hub_rd === 1'b0, "copy length");
      check(boot_parameter_register === ep, "parameter");
      check(clear_special === 8'h01 << res[2:0] && boot_param_load === 8'h01 << res[2:0], "init");
      check(start_pc === 9'h000 && core_run[res[2:0]] === 1'b1 && req_ready === 1'b1, "start");
   endtask
   task automatic summarize;
      $display("failures=%0d comparisons=%0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   initial begin
      // about 15k cycles of loading expected; 40k leaves ample margin
      #800_000;
      failures++;
      summarize();
   end
   initial begin
      rst_n = 1'b0;
      req_valid = 1'b0;
      req = '0;
      slow = 2'h0;
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      check(req_ready === 1'b1 && core_run === 8'h00 && clock_gate_en === 8'h00 && done === 1'b0, "reset");
      for (int i = 0; i < 8; i++) begin
         slow <= i[1:0];
         launch(op_launch_next, 3'h0, i[3:0], 16'h1000 + i[15:0] * 16'h0800, 16'hBEEF, 16'hBEEC);
      end
      check(clock_gate_en === 8'hFF && core_run === 8'hFF, "all running");
      issue(op_launch_next, 3'h0, 16'h2000, 16'h0000);
      check(result === 4'hF && nwr === 0, "none free");
      issue(op_stop, 3'h5, 16'h0000, 16'h0000);
      check(clock_gate_en === 8'hDF && core_run === 8'hDF, "stop 5");
      issue(op_stop, 3'h7, 16'h0000, 16'h0000);
      check(clock_gate_en === 8'h5F && core_run === 8'h5F, "stop 7");
      launch(op_launch_next, 3'h0, 4'h5, 16'hFC00, 16'h0003, 16'h0000);
      // non-address value 14'h0ABC handed over shifted left by two
      launch(op_launch_at, 3'h2, 4'h2, 16'h0040, {14'h0ABC, 2'b00}, 16'h2AF0);
      check(clock_gate_en === 8'h7F && core_run === 8'h7F, "relaunch");
      summarize();
   end
endmodule
